// File: tcm_consts.svh
// constants for the tape command interpreter
`ifndef TCM_CONSTS_SVH
`define TCM_CONSTS_SVH
`define TCM_OP_MODE_SENSE 8'h1A
`define TCM_OP_LOAD_UNLOAD 8'h1B
`define TCM_OP_RCV_DIAG 8'h1C
`define TCM_MS_LEN_BYTE 8'h0B
`define TCM_MS_MEDIUM 8'h00
`define TCM_MS_DESC_LEN 8'h08
`define TCM_MS_REC_BYTES 4'hC
`define TCM_DG_REC_BYTES 4'h9
`define TCM_ERR_OK 8'h00
`define TCM_REG_CFG 4'h0
`define TCM_REG_BLKLEN 4'h1
`define TCM_REG_DIAG0 4'h2
`define TCM_REG_DIAG1 4'h3
`define TCM_REG_DIAG2 4'h4
`define TCM_REG_STAT 4'h5
`define TCM_CFG_SPEED_LSB 0
`define TCM_CFG_BW_BIT 4
`define TCM_CFG_DEN_LSB 8
`define TCM_RST_SPEED 4'h0
`define TCM_RST_DENSITY 8'h02
`define TCM_SPEED_DEFAULT 4'h0
`define TCM_SPEED_LOW 4'h1
`define TCM_SPEED_HIGH 4'h2
`define TCM_DEN_NRZ_800 8'h01
`define TCM_DEN_PHASE_1600 8'h02
`define TCM_DEN_GROUP_6250 8'h03
`define TCM_DEN_DPE_3200 8'h06
`define TCM_SYNC_RST 16'h0000
`endif

// File: tcm_pkg.sv
// types shared by the tape command interpreter
`default_nettype none
package tcm_pkg;
  typedef enum logic [2:0] {
    TCM_IDLE = 3'b000,
    TCM_SEND = 3'b001,
    TCM_MOVE = 3'b010,
    TCM_DONE = 3'b011
  } tcm_state_e;
  typedef enum logic [7:0] {
    TCM_E_OK = 8'h00, TCM_E_MEM = 8'h80, TCM_E_FMK = 8'h81,
    TCM_E_ERASE = 8'h82, TCM_E_REWIND = 8'h83, TCM_E_BLANK = 8'h84,
    TCM_E_BLKLEN = 8'h85, TCM_E_DATA = 8'h86, TCM_E_PARITY = 8'h87,
    TCM_E_REVREAD = 8'h88, TCM_E_ABNORMAL = 8'h89
  } tcm_err_e;
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] b4;
    logic [7:0] b5;
  } tcm_cdb_s;
  // status byte 1 then status byte 2, msb first
  typedef struct packed {
    logic formatter_busy;
    logic data_busy;
    logic check_char_gate;
    logic end_of_tape_marker;
    logic ready;
    logic rewinding;
    logic file_protect;
    logic online;
    logic parity_error;
    logic file_mark;
    logic buffer_overflow;
    logic high_speed;
    logic nrz_density;
    logic beginning_of_tape_marker;
    logic formatter_busy_interrupt;
    logic data_busy_interrupt;
  } tcm_drv_s;
endpackage
`default_nettype wire

// File: tcm_core.sv
// tape target command interpreter: mode sense, load/unload, diag results
//
// Chosen here: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "tcm_consts.svh"
module tcm_core (
  input wire logic clk, // 50 MHz
  input wire logic sys_rst, // async, active high
  input wire logic [3:0] avs_address, // word index
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // low for one answer cycle
  input wire logic cmd_valid, // command block offered
  input wire tcm_pkg::tcm_cdb_s cmd_cdb, // six command bytes
  output logic cmd_ready, // command taken when both high
  output logic dat_valid, // data-in byte offered
  output logic [7:0] dat_byte, // data-in byte
  input wire logic dat_ready, // initiator takes byte
  output logic sts_valid, // status pulse
  output logic sts_check, // with sts_valid: check condition
  output logic sts_disconnect, // disconnect request pulse
  output logic sts_reselect, // reselect request pulse
  output logic mot_req, // tape motion request level
  output logic mot_load, // with mot_req: 1 load, 0 unload
  input wire logic mot_done_pin, // drive motion finished (async)
  input wire tcm_pkg::tcm_drv_s drv_pins, // drive status (async)
  output logic online, // controller online
  input wire logic wr_buffered, // write data reached buffer
  input wire logic wr_on_tape, // write data reached tape
  output logic wr_good // write good status pulse
);
  // registers
  tcm_pkg::tcm_state_e state_r;
  logic wait_r;
  logic [31:0] rdata_r;
  logic [3:0] speed_r;
  logic bw_r;
  logic [7:0] density_r;
  logic [23:0] blklen_r;
  logic [7:0] err_r, test_r, expect_r, actual_r;
  logic [23:0] info_r;
  logic cmd_ready_r, dat_valid_r, sts_valid_r, sts_check_r;
  logic sts_disc_r, sts_resel_r, mot_req_r, mot_load_r, online_r;
  logic wr_good_r, imm_r, is_ms_r;
  logic [7:0] dat_byte_r;
  logic [3:0] idx_r, len_r;
  logic [16:0] s1_r, s2_r, s3_r, stable_r;

  // three-stage sync; accept a change only once stages 2 and 3 agree
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_r <= 17'h0_0000;
      s2_r <= 17'h0_0000;
      s3_r <= 17'h0_0000;
      stable_r <= 17'h0_0000;
    end else begin
      s1_r <= {mot_done_pin, drv_pins};
      s2_r <= s1_r;
      s3_r <= s2_r;
      stable_r <= (s2_r & ~(s2_r ^ s3_r)) | (stable_r & (s2_r ^ s3_r));
    end
  end
  wire mot_done_s = stable_r[16];
  tcm_pkg::tcm_drv_s drv_s;
  assign drv_s = stable_r[15:0];
  wire wprot = drv_s.file_protect;

  // bus decode
  wire bus_req = avs_read | avs_write;
  wire bus_take = bus_req & wait_r;
  wire wr_en = avs_write & ~wait_r;
  wire sel_cfg = avs_address == `TCM_REG_CFG;
  wire sel_blk = avs_address == `TCM_REG_BLKLEN;
  wire sel_d0 = avs_address == `TCM_REG_DIAG0;
  wire sel_d1 = avs_address == `TCM_REG_DIAG1;
  wire sel_d2 = avs_address == `TCM_REG_DIAG2;
  wire sel_st = avs_address == `TCM_REG_STAT;
  wire [31:0] rd_mux =
    sel_cfg ? {16'h0000, density_r, 3'b000, bw_r, speed_r} :
    sel_blk ? {8'h00, blklen_r} :
    sel_d0 ? {16'h0000, test_r, err_r} :
    sel_d1 ? {8'h00, info_r} :
    sel_d2 ? {16'h0000, actual_r, expect_r} :
    sel_st ? {9'h000, state_r, mot_done_s, mot_req_r,
              online_r, 1'b0, drv_s} :
    32'h0000_0000;

  // one-cycle wait, answer on the next edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      wait_r <= ~bus_take;
      if (bus_take) begin
        rdata_r <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      speed_r <= `TCM_RST_SPEED;
      bw_r <= 1'b0;
      density_r <= `TCM_RST_DENSITY;
      blklen_r <= 24'h00_0000;
      err_r <= `TCM_ERR_OK;
      test_r <= 8'h00;
      info_r <= 24'h00_0000;
      expect_r <= 8'h00;
      actual_r <= 8'h00;
    end else if (wr_en) begin
      if (sel_cfg) begin
        speed_r <= avs_writedata[`TCM_CFG_SPEED_LSB +: 4];
        bw_r <= avs_writedata[`TCM_CFG_BW_BIT];
        density_r <= avs_writedata[`TCM_CFG_DEN_LSB +: 8];
      end
      if (sel_blk) begin
        blklen_r <= avs_writedata[23:0];
      end
      if (sel_d0) begin
        err_r <= avs_writedata[7:0];
        test_r <= avs_writedata[15:8];
      end
      if (sel_d1) begin
        info_r <= avs_writedata[23:0];
      end
      if (sel_d2) begin
        expect_r <= avs_writedata[7:0];
        actual_r <= avs_writedata[15:8];
      end
    end
  end

  // mode-sense record
  wire [7:0] ms_b2 = {wprot, 2'b00, bw_r, speed_r};
  wire [7:0] ms_rec [0:11];
  assign ms_rec[0] = `TCM_MS_LEN_BYTE;
  assign ms_rec[1] = `TCM_MS_MEDIUM;
  assign ms_rec[2] = ms_b2;
  assign ms_rec[3] = `TCM_MS_DESC_LEN;
  assign ms_rec[4] = density_r;
  assign ms_rec[5] = 8'h00;
  assign ms_rec[6] = 8'h00;
  assign ms_rec[7] = 8'h00;
  assign ms_rec[8] = 8'h00;
  assign ms_rec[9] = blklen_r[23:16];
  assign ms_rec[10] = blklen_r[15:8];
  assign ms_rec[11] = blklen_r[7:0];

  // diagnostic record; test number forced zero without an error
  wire [7:0] dg_rec [0:8];
  assign dg_rec[0] = err_r;
  assign dg_rec[1] = (err_r == `TCM_ERR_OK) ? 8'h00 : test_r;
  assign dg_rec[2] = info_r[23:16];
  assign dg_rec[3] = info_r[15:8];
  assign dg_rec[4] = info_r[7:0];
  assign dg_rec[5] = expect_r;
  assign dg_rec[6] = actual_r;
  assign dg_rec[7] = drv_s[15:8];
  assign dg_rec[8] = drv_s[7:0];

  // command decode
  wire cmd_take = cmd_valid & cmd_ready_r;
  wire op_ms = cmd_cdb.opcode == `TCM_OP_MODE_SENSE;
  wire op_lu = cmd_cdb.opcode == `TCM_OP_LOAD_UNLOAD;
  wire op_dg = cmd_cdb.opcode == `TCM_OP_RCV_DIAG;
  wire lu_imm = cmd_cdb.b1[0]; // immediate_status_flag
  wire lu_load = cmd_cdb.b4[0];
  wire [15:0] dg_alloc = {cmd_cdb.b3, cmd_cdb.b4};
  // clamp to record size; a zero length sends nothing
  wire [3:0] ms_len = (cmd_cdb.b4 > {4'h0, `TCM_MS_REC_BYTES}) ?
    `TCM_MS_REC_BYTES : cmd_cdb.b4[3:0];
  wire [3:0] dg_len = (dg_alloc > {12'h000, `TCM_DG_REC_BYTES}) ?
    `TCM_DG_REC_BYTES : dg_alloc[3:0];
  wire [3:0] new_len = op_ms ? ms_len : dg_len;
  wire [3:0] next_idx = (state_r == tcm_pkg::TCM_SEND) ?
    idx_r + 4'h1 : 4'h0;
  wire next_ms = (state_r == tcm_pkg::TCM_SEND) ? is_ms_r : op_ms;
  wire [7:0] next_byte = next_ms ? ms_rec[next_idx] :
    ((next_idx < `TCM_DG_REC_BYTES) ? dg_rec[next_idx] : 8'h00);
  wire last_beat = dat_valid_r & dat_ready & (next_idx == len_r);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= tcm_pkg::TCM_IDLE;
      cmd_ready_r <= 1'b0;
      dat_valid_r <= 1'b0;
      dat_byte_r <= 8'h00;
      idx_r <= 4'h0;
      len_r <= 4'h0;
      is_ms_r <= 1'b0;
      imm_r <= 1'b0;
      sts_valid_r <= 1'b0;
      sts_check_r <= 1'b0;
      sts_disc_r <= 1'b0;
      sts_resel_r <= 1'b0;
      mot_req_r <= 1'b0;
      mot_load_r <= 1'b0;
      online_r <= 1'b0;
    end else begin
      sts_valid_r <= 1'b0;
      sts_disc_r <= 1'b0;
      sts_resel_r <= 1'b0;
      case (state_r)
        tcm_pkg::TCM_IDLE: begin
          cmd_ready_r <= 1'b1;
          if (cmd_take) begin
            cmd_ready_r <= 1'b0;
            sts_check_r <= 1'b0;
            if ((op_ms | op_dg) && new_len != 4'h0) begin
              state_r <= tcm_pkg::TCM_SEND;
              is_ms_r <= op_ms;
              len_r <= new_len;
              idx_r <= 4'h0;
              dat_valid_r <= 1'b1;
              dat_byte_r <= next_byte;
            end else if (op_ms | op_dg) begin
              state_r <= tcm_pkg::TCM_DONE;
              sts_valid_r <= 1'b1;
            end else if (op_lu) begin
              state_r <= tcm_pkg::TCM_MOVE;
              imm_r <= lu_imm;
              mot_req_r <= 1'b1;
              mot_load_r <= lu_load;
              // unload drops online at once; drive then unwinds
              if (!lu_load) begin
                online_r <= 1'b0;
              end
              sts_valid_r <= lu_imm;
              sts_disc_r <= ~lu_imm;
            end else begin
              state_r <= tcm_pkg::TCM_DONE;
              sts_valid_r <= 1'b1;
              sts_check_r <= 1'b1;
            end
          end
        end
        tcm_pkg::TCM_SEND: begin
          if (dat_valid_r && dat_ready) begin
            if (last_beat) begin
              dat_valid_r <= 1'b0;
              sts_valid_r <= 1'b1;
              state_r <= tcm_pkg::TCM_DONE;
            end else begin
              idx_r <= next_idx;
              dat_byte_r <= next_byte;
            end
          end
        end
        tcm_pkg::TCM_MOVE: begin
          // wait for the drive's synchronised completion
          if (mot_done_s) begin
            mot_req_r <= 1'b0;
            if (mot_load_r) begin
              online_r <= 1'b1;
            end
            sts_resel_r <= ~imm_r;
            sts_valid_r <= ~imm_r;
            state_r <= tcm_pkg::TCM_DONE;
          end
        end
        tcm_pkg::TCM_DONE: begin
          // drive must drop its done level before the next motion
          if (!mot_done_s) begin
            state_r <= tcm_pkg::TCM_IDLE;
          end
        end
        default: begin
          state_r <= tcm_pkg::TCM_IDLE;
        end
      endcase
    end
  end

  // write status: buffer arrival if buffered, else tape completion
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_good_r <= 1'b0;
    end else begin
      wr_good_r <= bw_r ? wr_buffered : wr_on_tape;
    end
  end

  assign avs_waitrequest = wait_r;
  assign avs_readdata = rdata_r;
  assign cmd_ready = cmd_ready_r;
  assign dat_valid = dat_valid_r;
  assign dat_byte = dat_byte_r;
  assign sts_valid = sts_valid_r;
  assign sts_check = sts_check_r;
  assign sts_disconnect = sts_disc_r;
  assign sts_reselect = sts_resel_r;
  assign mot_req = mot_req_r;
  assign mot_load = mot_load_r;
  assign online = online_r;
  assign wr_good = wr_good_r;

  // checks
  AST_MS_HDR: assert property (@(posedge clk) disable iff (sys_rst)
    dat_valid_r && is_ms_r && idx_r == 4'h0 |-> dat_byte_r == 8'h0B)
    else $error("mode sense header byte wrong");
  AST_LEN_LIMIT: assert property (@(posedge clk) disable iff (sys_rst)
    dat_valid_r |-> idx_r < len_r && len_r <= 4'hC)
    else $error("data index past limit");
  AST_SPEED_WP: assert property (@(posedge clk) disable iff (sys_rst)
    dat_valid_r && is_ms_r && idx_r == 4'h2 |->
    dat_byte_r == {wprot, 2'b00, bw_r, speed_r})
    else $error("mode sense byte 2 wrong");
  AST_BUFWR: assert property (@(posedge clk) disable iff (sys_rst)
    bw_r && $stable(bw_r) && wr_buffered |=> wr_good_r)
    else $error("buffered write not acknowledged");
  AST_IMMEDIATE: assert property (@(posedge clk) disable iff (sys_rst)
    cmd_take && op_lu && lu_imm |=> sts_valid_r && !sts_disc_r)
    else $error("immediate status missing");
  AST_DISC: assert property (@(posedge clk) disable iff (sys_rst)
    cmd_take && op_lu && !lu_imm |=> sts_disc_r && !sts_valid_r)
    else $error("disconnect missing");
  AST_UNLOAD: assert property (@(posedge clk) disable iff (sys_rst)
    cmd_take && op_lu && !lu_load |=> !online_r && mot_req_r && !mot_load_r)
    else $error("unload did not go offline");
  AST_DG_MAX: assert property (@(posedge clk) disable iff (sys_rst)
    dat_valid_r && !is_ms_r |-> len_r <= 4'h9 && len_r != 4'h0)
    else $error("diagnostic length past record");
  AST_LOAD: assert property (@(posedge clk) disable iff (sys_rst)
    state_r == tcm_pkg::TCM_MOVE && mot_done_s && mot_load_r |=>
    online_r && !mot_req_r)
    else $error("load did not set online");
  AST_TESTNUM: assert property (@(posedge clk) disable iff (sys_rst)
    dat_valid_r && !is_ms_r && idx_r == 4'h1 && err_r == 8'h00 |->
    dat_byte_r == 8'h00)
    else $error("test number without error");
  AST_ZERO_ALLOC: assert property (@(posedge clk) disable iff (sys_rst)
    cmd_take && op_dg && dg_alloc == 16'h0000 |=>
    !dat_valid_r && sts_valid_r)
    else $error("zero allocation sent data");
  COV_MS: cover property (@(posedge clk) disable iff (sys_rst)
    last_beat && is_ms_r && len_r == 4'hC);
  COV_DG: cover property (@(posedge clk) disable iff (sys_rst)
    last_beat && !is_ms_r && len_r == 4'h9);
  COV_UNLOAD: cover property (@(posedge clk) disable iff (sys_rst)
    sts_resel_r && !mot_load_r);
  COV_IMM_LOAD: cover property (@(posedge clk) disable iff (sys_rst)
    sts_valid_r && mot_req_r && mot_load_r);
endmodule
`default_nettype wire

// File: tcm_init_model.sv
// initiator model: offers command blocks, takes data-in bytes, counts status
`timescale 1ns/1ps
`default_nettype none
module tcm_init_model (
  input wire logic clk, // system clock
  input wire logic sys_rst, // async reset, active high
  input wire logic slow, // stall data-in at random
  input wire logic rnd, // random bit from the bench
  output logic cmd_valid, // command block offered
  output var tcm_pkg::tcm_cdb_s cmd_cdb, // command block
  input wire logic cmd_ready, // target takes the block
  input wire logic dat_valid, // data-in byte offered
  input wire logic [7:0] dat_byte, // data-in byte
  output logic dat_ready, // byte accepted
  input wire logic sts_valid, // status pulse
  input wire logic sts_check // check condition with status
);
  logic [7:0] rx_q[$];
  int n_sts = 0;
  logic last_check = 1'b0;
  initial begin
    cmd_valid = 1'b0;
    cmd_cdb = '0;
    dat_ready = 1'b0;
  end
  // random stalls prove the target holds each byte until taken
  always @(posedge clk) begin
    dat_ready <= !sys_rst && (!slow || rnd);
    if (dat_valid && dat_ready)
      rx_q.push_back(dat_byte);
    if (sts_valid) begin
      n_sts <= n_sts + 1;
      last_check <= sts_check;
    end
  end
  // entered just after an edge; block held until taken, then scrambled
  task automatic send_cmd(input tcm_pkg::tcm_cdb_s c);
    cmd_valid <= 1'b1;
    cmd_cdb <= c;
    @(posedge clk);
    while (!cmd_ready) @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_cdb <= ~c;
  endtask
endmodule
`default_nettype wire

// File: tcm_tb.sv
// self-checking bench for the tape command interpreter
`timescale 1ns/1ps
`default_nettype none
`include "tcm_consts.svh"
module tb;
  localparam logic [7:0] DENS [4] = '{8'h01, 8'h02, 8'h03, 8'h06};
  localparam logic [7:0] LENS [6] = '{8'h00, 8'h01, 8'h05, 8'h0B, 8'h0C, 8'hC8};
  localparam logic [15:0] ALS [6] = '{16'h0000, 16'h0001, 16'h0009,
    16'h000A, 16'h0100, 16'h0003};
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata, rd, v;
  logic avs_waitrequest, cmd_valid, cmd_ready, dat_valid, dat_ready;
  logic sts_valid, sts_check, sts_disconnect, sts_reselect;
  logic mot_req, mot_load, online, wr_good;
  tcm_pkg::tcm_cdb_s cmd_cdb;
  logic [7:0] dat_byte, den, err, tst;
  logic mot_done_pin = 1'b0;
  tcm_pkg::tcm_drv_s drv_pins = 16'h0000;
  logic wr_buffered = 1'b0;
  logic wr_on_tape = 1'b0;
  logic slow = 1'b0;
  int seed = 32'h00fd42fc;
  logic [31:0] rnd_r = 32'h0000_0000;
  int n_errors = 0, checks = 0, cyc = 0, n_disc = 0, n_resel = 0;
  int n_good = 0, mcnt = 0, g0, d0;
  logic sts_done = 1'b0, sts_resel = 1'b0, mload = 1'b0;
  logic [3:0] spd;
  logic bw, wp;
  logic [23:0] bl;
  logic [15:0] al;
  logic [7:0] exp_q[$];

  always #10 clk = ~clk;

  tcm_core dut_u (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cmd_valid(cmd_valid),
    .cmd_cdb(cmd_cdb), .cmd_ready(cmd_ready), .dat_valid(dat_valid),
    .dat_byte(dat_byte), .dat_ready(dat_ready), .sts_valid(sts_valid),
    .sts_check(sts_check), .sts_disconnect(sts_disconnect),
    .sts_reselect(sts_reselect), .mot_req(mot_req), .mot_load(mot_load),
    .mot_done_pin(mot_done_pin), .drv_pins(drv_pins), .online(online),
    .wr_buffered(wr_buffered), .wr_on_tape(wr_on_tape), .wr_good(wr_good));

  tcm_init_model init_u (.clk(clk), .sys_rst(sys_rst), .slow(slow),
    .rnd(rnd_r[0]), .cmd_valid(cmd_valid), .cmd_cdb(cmd_cdb),
    .cmd_ready(cmd_ready), .dat_valid(dat_valid), .dat_byte(dat_byte),
    .dat_ready(dat_ready), .sts_valid(sts_valid), .sts_check(sts_check));

  // drive mechanics: done rises after a while, held until request drops
  always @(posedge clk) begin
    rnd_r <= $random(seed);
    cyc <= cyc + 1;
    if (!mot_req) begin
      mot_done_pin <= 1'b0;
      mcnt <= 0;
    end else if (mcnt == 8)
      mot_done_pin <= 1'b1;
    else
      mcnt <= mcnt + 1;
    if (mot_req)
      mload <= mot_load;
    if (sts_disconnect)
      n_disc <= n_disc + 1;
    if (sts_reselect)
      n_resel <= n_resel + 1;
    if (wr_good)
      n_good <= n_good + 1;
    if (sts_valid) begin
      sts_done <= mot_done_pin;
      sts_resel <= sts_reselect;
    end
    if (cyc == 20000) begin
      n_errors++;
      $display("Error t=%0t exp=%h got=%h", $time, 0, cyc);
      stop_test();
    end
  end

  task automatic stop_test;
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic cmp32(input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic cmp8(input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // one access; the extra edge keeps back-to-back calls from colliding
  task automatic avs_xfer(input logic wr, input logic [3:0] a,
      input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest) @(posedge clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask

  task automatic avs_wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    avs_xfer(1'b1, a, d, q);
  endtask

  task automatic run_cmd(input tcm_pkg::tcm_cdb_s c);
    int n0;
    n0 = init_u.n_sts;
    init_u.rx_q.delete();
    init_u.send_cmd(c);
    while (init_u.n_sts == n0) @(posedge clk);
    while (!cmd_ready) @(posedge clk);
  endtask

  task automatic chk_rx(input int n);
    cmp32(n, init_u.rx_q.size());
    cmp8(8'h00, {7'h0, init_u.last_check});
    for (int i = 0; i < n && i < init_u.rx_q.size(); i++)
      cmp8(exp_q[i], init_u.rx_q[i]);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    avs_xfer(1'b0, `TCM_REG_CFG, 32'h0, rd);
    cmp32(32'h0000_0200, rd);
    avs_wr(4'hF, 32'hFFFF_FFFF);
    avs_xfer(1'b0, 4'hF, 32'h0, rd);
    cmp32(32'h0000_0000, rd);
    $display("register test done");
    for (int k = 0; k < 12; k++) begin
      spd = 4'(k % 3);
      den = DENS[k % 4];
      bw = rnd_r[1];
      wp = rnd_r[2];
      bl = k[0] ? 24'(rnd_r[14:0]) + 24'h00_0002 : 24'h00_0000;
      slow <= k[1];
      drv_pins <= {6'h00, wp, 9'h000};
      avs_wr(`TCM_REG_CFG, {16'h0000, den, 3'h0, bw, spd});
      avs_wr(`TCM_REG_BLKLEN, {8'h00, bl});
      repeat (6) @(posedge clk);
      exp_q = '{8'h0B, 8'h00, {wp, 2'b00, bw, spd}, 8'h08, den, 8'h00,
        8'h00, 8'h00, 8'h00, bl[23:16], bl[15:8], bl[7:0]};
      run_cmd({8'h1A, 24'h00_0000, LENS[k % 6], 8'h00});
      chk_rx(LENS[k % 6] < 12 ? LENS[k % 6] : 12);
    end
    $display("mode sense test done");
    for (int e = 0; e < 11; e++) begin
      v = $random(seed);
      err = e == 0 ? 8'h00 : 8'(8'h7F + e);
      tst = v[23:16] | 8'h01;
      al = ALS[e % 6];
      drv_pins <= v[15:0];
      avs_wr(`TCM_REG_DIAG0, {16'h0000, tst, err});
      bl = rnd_r[23:0];
      avs_wr(`TCM_REG_DIAG1, {8'h00, bl});
      exp_q = '{err, e == 0 ? 8'h00 : tst, bl[23:16], bl[15:8],
        bl[7:0], v[31:24], v[23:16], v[15:8], v[7:0]};
      avs_wr(`TCM_REG_DIAG2, {16'h0000, v[23:16], v[31:24]});
      repeat (6) @(posedge clk);
      avs_xfer(1'b0, `TCM_REG_STAT, 32'h0, rd);
      cmp32({16'h0000, v[15:0]}, {16'h0000, rd[15:0]});
      run_cmd({8'h1C, 16'h0000, al, 8'h00});
      chk_rx(al > 9 ? 9 : al);
    end
    $display("diagnostic test done");
    run_cmd({8'h3B, 40'h00_0000_0000});
    cmp8(8'h01, {7'h0, init_u.last_check});
    cmp32(0, init_u.rx_q.size());
    for (int b = 0; b < 2; b++) begin
      avs_wr(`TCM_REG_CFG, {16'h0000, 8'h02, 3'h0, b[0], 4'h0});
      g0 = n_good;
      wr_buffered <= 1'b1;
      @(posedge clk);
      wr_buffered <= 1'b0;
      repeat (4) @(posedge clk);
      cmp32(g0 + b, n_good);
      if (b == 0) begin
        wr_on_tape <= 1'b1;
        @(posedge clk);
        wr_on_tape <= 1'b0;
        repeat (4) @(posedge clk);
        cmp32(g0 + 1, n_good);
      end
    end
    $display("write status test done");
    for (int k = 0; k < 4; k++) begin
      d0 = n_disc;
      g0 = n_resel;
      run_cmd({8'h1B, 7'h0, k[0], 16'h0000, 7'h0, k[1], 8'h00});
      cmp32(k[0] ? d0 : d0 + 1, n_disc);
      cmp32(k[0] ? g0 : g0 + 1, n_resel);
      cmp8({7'h0, !k[0]}, {7'h0, sts_resel});
      if (k[0])
        cmp8(8'h00, {7'h0, sts_done});
      cmp8({7'h0, k[1]}, {7'h0, mload});
      cmp8({7'h0, k[1]}, {7'h0, online});
    end
    $display("load unload test done");
    stop_test();
  end
endmodule
`default_nettype wire
